// *** rtl/siop_pkg.sv ***
// Constants for the two-pin status/general I/O port.
// Assumes one 100 MHz clock and an AHB-Lite master for software.
// Contract
// - Protection status: high when clear, low when active
// - Inverted polarity drives the exact opposite level
// - Off status: high when off, low when on
// - Output True is logic 1, low normally
// - Output False is logic 0, high normally
// - Output mode sends static 1, 0 or PWM
// - PWM frequency and duty are separate settings
// - Input mode senses and reports the pin level
// - Polarity inverts both sent and received signals
// - Function choice: status, input, output; status default
// - Unconnected input reads 1, inverted reads 0
// - Duty sets the low fraction of each period
`default_nettype none

package siop_pkg;

    localparam int          NPIN      = 2;
    localparam int          CLK_HZ    = 100_000_000;
    localparam int          PH_W      = 27;
    localparam int          DUTY_W    = 7;
    localparam int          DUTY_MAX  = 100;
    localparam int          DUTY_STEP = CLK_HZ / DUTY_MAX;
    localparam int          FREQ_MAX  = CLK_HZ / 2;

    // Register byte offsets
    localparam logic [7:0]  CFG_BASE    = 8'h00;
    localparam logic [7:0]  FREQ_BASE   = 8'h08;
    localparam logic [7:0]  DUTY_BASE   = 8'h0C;
    localparam logic [7:0]  PIN_STRIDE  = 8'h08;
    localparam logic [7:0]  STATUS_ADDR = 8'h18;

    // Configuration word fields
    localparam int          FUNC_LSB  = 0;
    localparam int          INV_BIT   = 2;
    localparam int          SEL_LSB   = 4;

    // Status word fields
    localparam int          ST_IN_LSB   = 0;
    localparam int          ST_LVL_LSB  = 2;
    localparam int          ST_PROT_BIT = 4;
    localparam int          ST_ON_BIT   = 5;

    localparam logic [PH_W-1:0]   FREQ_RST = 27'h000_0064;
    localparam logic [DUTY_W-1:0] DUTY_RST = 7'h0A;

    typedef enum logic [1:0] {
        FN_STATUS = 2'b00,
        FN_INPUT  = 2'b01,
        FN_OUTPUT = 2'b10
    } siop_func_t;

    typedef enum logic [1:0] {
        SEL_FALSE = 2'b00,
        SEL_TRUE  = 2'b01,
        SEL_PWM   = 2'b10
    } siop_sel_t;

endpackage : siop_pkg

`default_nettype wire

// *** rtl/siop_pwm.sv ***
// Phase-accumulator PWM source for one pin.
// Assumes freq at most half the clock rate and duty at most 100.
`default_nettype none

module siop_pwm
    import siop_pkg::*;
#(
    parameter int PW = PH_W
) (
    // Clock and reset
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // Settings
    input  wire logic              run,
    input  wire logic [PW-1:0]     freq,
    input  wire logic [DUTY_W-1:0] duty,
    // Waveform, 1 during the low phase
    output logic                   low_r
);

    logic [PW-1:0] acc_r;
    logic [PW:0]   sum;
    logic [33:0]   prod;
    logic [PW-1:0] thresh;

    // Average period is exactly CLK_HZ/freq cycles, no divider needed
    always_comb begin
        sum    = {1'b0, acc_r} + {1'b0, freq};
        prod   = 34'(duty) * 34'(DUTY_STEP);
        thresh = prod[PW-1:0];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_r <= '0;
        end else if (!run) begin
            acc_r <= '0;
        end else if (sum >= (PW+1)'(CLK_HZ)) begin
            acc_r <= PW'(sum - (PW+1)'(CLK_HZ));
        end else begin
            acc_r <= sum[PW-1:0];
        end
    end

    // Low phase leads each period
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_r <= 1'b0;
        end else begin
            low_r <= run && (acc_r < thresh);
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    phase_range_a: assert property (acc_r < PW'(CLK_HZ))
        else $error("pwm phase out of range");
    full_duty_a: assert property (
        (run && duty == DUTY_W'(DUTY_MAX)) |=> low_r)
        else $error("full duty not low");
    zero_duty_a: assert property ((duty == '0) |=> !low_r)
        else $error("zero duty went low");

endmodule : siop_pwm

`default_nettype wire

// *** rtl/siop_pins.sv ***
// Two configurable status/general I/O pins with an AHB-Lite slave.
// Assumes all inputs synchronous to hclk; pin wire resolved outside.
`default_nettype none

module siop_pins
    import siop_pkg::*;
(
    // Clock and reset
    input  wire logic            hclk,
    input  wire logic            hresetn,
    // AHB-Lite slave
    input  wire logic            hsel,
    input  wire logic [31:0]     haddr,
    input  wire logic [1:0]      htrans,
    input  wire logic            hwrite,
    input  wire logic [2:0]      hsize,
    input  wire logic [31:0]     hwdata,
    input  wire logic            hready,
    output logic [31:0]          hrdata,
    output logic                 hreadyout,
    output logic                 hresp,
    // Instrument state
    input  wire logic            protection_active,
    input  wire logic            output_on,
    // Pins
    input  wire logic [NPIN-1:0] pin_in,
    output logic [NPIN-1:0]      pin_out,
    output logic [NPIN-1:0]      pin_oe_n
);

    logic [NPIN-1:0][1:0]        func_r;
    logic [NPIN-1:0]             inv_r;
    logic [NPIN-1:0][1:0]        sel_r;
    logic [NPIN-1:0][PH_W-1:0]   freq_r;
    logic [NPIN-1:0][DUTY_W-1:0] duty_r;
    logic [NPIN-1:0]             in_state_r;
    logic [NPIN-1:0]             pwm_low;
    logic [NPIN-1:0]             stat_src;
    logic [NPIN-1:0]             logic_val;
    logic [NPIN-1:0]             pwm_run;

    logic                        wr_pend_r;
    logic                        rd_pend_r;
    logic [7:0]                  acc_addr_r;
    logic [31:0]                 rd_nxt;
    logic                        take;

    // Bus address phase
    assign take = hsel && hready && htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r  <= 1'b0;
            rd_pend_r  <= 1'b0;
            acc_addr_r <= 8'h00;
        end else begin
            wr_pend_r <= take && hwrite && (hsize == 3'b010);
            rd_pend_r <= take && !hwrite;
            if (take) begin
                acc_addr_r <= haddr[7:0];
            end
        end
    end

    // Reads take one wait state so a write just before is seen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hrdata    <= 32'h0000_0000;
            hresp     <= 1'b0;
        end else begin
            hresp <= 1'b0;
            if (take && !hwrite) begin
                hreadyout <= 1'b0;
            end else if (rd_pend_r) begin
                hreadyout <= 1'b1;
                hrdata    <= rd_nxt;
            end
        end
    end

    // Read multiplexer; unmapped offsets read zero
    always_comb begin
        rd_nxt = 32'h0000_0000;
        for (int i = 0; i < NPIN; i++) begin
            if (acc_addr_r == CFG_BASE + 8'(4 * i)) begin
                rd_nxt[FUNC_LSB +: 2] = func_r[i];
                rd_nxt[INV_BIT]       = inv_r[i];
                rd_nxt[SEL_LSB +: 2]  = sel_r[i];
            end else if (acc_addr_r ==
                         FREQ_BASE + 8'(i) * PIN_STRIDE) begin
                rd_nxt[PH_W-1:0] = freq_r[i];
            end else if (acc_addr_r ==
                         DUTY_BASE + 8'(i) * PIN_STRIDE) begin
                rd_nxt[DUTY_W-1:0] = duty_r[i];
            end
        end
        if (acc_addr_r == STATUS_ADDR) begin
            rd_nxt[ST_IN_LSB +: NPIN]  = in_state_r;
            rd_nxt[ST_LVL_LSB +: NPIN] = pin_out;
            rd_nxt[ST_PROT_BIT]        = protection_active;
            rd_nxt[ST_ON_BIT]          = output_on;
        end
    end

    // Configuration registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            func_r <= '0;
            inv_r  <= '0;
            sel_r  <= '0;
        end else if (wr_pend_r) begin
            for (int i = 0; i < NPIN; i++) begin
                if (acc_addr_r == CFG_BASE + 8'(4 * i)) begin
                    // Unknown codes fall back to the status function and to SEL_FALSE
                    if (hwdata[FUNC_LSB +: 2] == 2'b11) begin
                        func_r[i] <= FN_STATUS;
                    end else begin
                        func_r[i] <= hwdata[FUNC_LSB +: 2];
                    end
                    inv_r[i] <= hwdata[INV_BIT];
                    if (hwdata[SEL_LSB +: 2] == 2'b11) begin
                        sel_r[i] <= SEL_FALSE;
                    end else begin
                        sel_r[i] <= hwdata[SEL_LSB +: 2];
                    end
                end
            end
        end
    end

    // PWM frequency and duty, saturated so the waveform stays defined
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NPIN; i++) begin
                freq_r[i] <= FREQ_RST;
                duty_r[i] <= DUTY_RST;
            end
        end else if (wr_pend_r) begin
            for (int i = 0; i < NPIN; i++) begin
                if (acc_addr_r == FREQ_BASE + 8'(i) * PIN_STRIDE) begin
                    if (hwdata > 32'(FREQ_MAX)) begin
                        freq_r[i] <= PH_W'(FREQ_MAX);
                    end else begin
                        freq_r[i] <= hwdata[PH_W-1:0];
                    end
                end else if (acc_addr_r ==
                             DUTY_BASE + 8'(i) * PIN_STRIDE) begin
                    if (hwdata > 32'(DUTY_MAX)) begin
                        duty_r[i] <= DUTY_W'(DUTY_MAX);
                    end else begin
                        duty_r[i] <= hwdata[DUTY_W-1:0];
                    end
                end
            end
        end
    end

    // Status sources: pin 0 protection, pin 1 main output on
    assign stat_src[0] = protection_active;
    assign stat_src[1] = output_on;

    genvar g;
    generate
        for (g = 0; g < NPIN; g++) begin : g_pin
            assign pwm_run[g] = (func_r[g] == FN_OUTPUT) &&
                                (sel_r[g] == SEL_PWM);

            siop_pwm u_pwm (
                .hclk    (hclk),
                .hresetn (hresetn),
                .run     (pwm_run[g]),
                .freq    (freq_r[g]),
                .duty    (duty_r[g]),
                .low_r   (pwm_low[g])
            );
        end
    endgenerate

    // Logic value per pin; logic 1 means a low level at normal polarity
    always_comb begin
        for (int i = 0; i < NPIN; i++) begin
            logic_val[i] = 1'b0;
            if (func_r[i] == FN_STATUS) begin
                logic_val[i] = stat_src[i];
            end else if (sel_r[i] == SEL_TRUE) begin
                logic_val[i] = 1'b1;
            end else if (sel_r[i] == SEL_PWM) begin
                logic_val[i] = pwm_low[i];
            end
        end
    end

    // Pin drivers; input mode releases the pin
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_out  <= '1;
            pin_oe_n <= '0;
        end else begin
            for (int i = 0; i < NPIN; i++) begin
                pin_out[i]  <= !(logic_val[i] ^ inv_r[i]);
                pin_oe_n[i] <= (func_r[i] == FN_INPUT);
            end
        end
    end

    // Input sensing; an open pin floats high and reads 1, or 0 when inverted
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            in_state_r <= '0;
        end else begin
            for (int i = 0; i < NPIN; i++) begin
                if (func_r[i] == FN_INPUT) begin
                    in_state_r[i] <= pin_in[i] ^ inv_r[i];
                end else begin
                    in_state_r[i] <= 1'b0;
                end
            end
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence prot_norm_s;
        func_r[0] == FN_STATUS && !inv_r[0];
    endsequence

    sequence off_norm_s;
        func_r[1] == FN_STATUS && !inv_r[1];
    endsequence

    sequence pwm_sel_s(int i);
        func_r[i] == FN_OUTPUT && sel_r[i] == SEL_PWM;
    endsequence

    sequence in_mode_s(int i);
        func_r[i] == FN_INPUT;
    endsequence

    sequence out_sel_s(int i, logic [1:0] s);
        func_r[i] == FN_OUTPUT && sel_r[i] == s;
    endsequence

    prot_level_a: assert property (
        prot_norm_s ##0 $stable(func_r[0]) |=>
            pin_out[0] == !$past(protection_active) && !pin_oe_n[0])
        else $error("protection status level wrong");

    prot_invert_a: assert property (
        (func_r[0] == FN_STATUS && inv_r[0]) |=>
            pin_out[0] == $past(protection_active))
        else $error("inverted protection level wrong");

    off_level_a: assert property (
        off_norm_s |=> pin_out[1] == !$past(output_on))
        else $error("off status level wrong");

    gen_true_a: assert property (
        (func_r[0] == FN_OUTPUT && sel_r[0] == SEL_TRUE) |=>
            pin_out[0] == $past(inv_r[0]) && !pin_oe_n[0])
        else $error("true output level wrong");

    gen_false_a: assert property (
        (func_r[1] == FN_OUTPUT && sel_r[1] == SEL_FALSE) |=>
            pin_out[1] == !$past(inv_r[1]))
        else $error("false output level wrong");

    pwm_drive_a: assert property (
        pwm_sel_s(0) |=> pin_out[0] == !($past(pwm_low[0]) ^
                                         $past(inv_r[0])))
        else $error("pwm level not driven");

    pwm_idle_a: assert property (
        !pwm_run[0] ##1 !pwm_run[0] |=> !pwm_low[0])
        else $error("pwm active while not selected");

    input_sense_a: assert property (
        (func_r[1] == FN_INPUT) ##1 (func_r[1] == FN_INPUT) |->
            pin_oe_n[1] && in_state_r[1] ==
            ($past(pin_in[1]) ^ $past(inv_r[1])))
        else $error("input state wrong");

    func_legal_a: assert property (
        func_r[0] != 2'b11 && func_r[1] != 2'b11)
        else $error("illegal function code held");

    read_wait_a: assert property (
        (take && !hwrite) |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");

    off_invert_a: assert property (
        (func_r[1] == FN_STATUS && inv_r[1]) |=>
            pin_out[1] == $past(output_on))
        else $error("inverted off status level wrong");

    drive_enable_a: assert property (
        (func_r[0] != FN_INPUT) |=> !pin_oe_n[0])
        else $error("pin not driven outside input mode");

    open_high_a: assert property (
        in_mode_s(0) ##0 (!inv_r[0] && pin_in[0]) |=> in_state_r[0])
        else $error("high input not read as 1");

    open_invert_a: assert property (
        in_mode_s(0) ##0 (inv_r[0] && pin_in[0]) |=> !in_state_r[0])
        else $error("inverted high input not read as 0");

    in_cleared_a: assert property (
        (func_r[1] != FN_INPUT) |=> !in_state_r[1])
        else $error("input state set outside input mode");

    true_pin1_a: assert property (
        out_sel_s(1, SEL_TRUE) |=> pin_out[1] == $past(inv_r[1]))
        else $error("pin 1 true level wrong");

    false_pin0_a: assert property (
        out_sel_s(0, SEL_FALSE) |=> pin_out[0] == !$past(inv_r[0]))
        else $error("pin 0 false level wrong");

    pwm_invert_a: assert property (
        out_sel_s(1, SEL_PWM) |=> pin_out[1] == !($past(pwm_low[1]) ^
                                                  $past(inv_r[1])))
        else $error("pin 1 pwm level wrong");

    // A fresh PWM selection must open with its low phase
    pwm_start_a: assert property (
        ($rose(pwm_run[0]) && duty_r[0] != '0) |=> pwm_low[0])
        else $error("pwm did not start in low phase");

    limit_range_a: assert property (
        freq_r[0] <= PH_W'(FREQ_MAX) && freq_r[1] <= PH_W'(FREQ_MAX) &&
        duty_r[0] <= DUTY_W'(DUTY_MAX) && duty_r[1] <= DUTY_W'(DUTY_MAX))
        else $error("pwm setting above its limit");

    sel_legal_a: assert property (
        sel_r[0] != 2'b11 && sel_r[1] != 2'b11)
        else $error("illegal output select held");

    resp_okay_a: assert property (!hresp)
        else $error("error response driven");

endmodule : siop_pins

`default_nettype wire

// *** verif/siop_ext.sv ***
// Instrument on the far side of the two pins: probe with pull-up.
// Assumes pin_oe_n low means the block drives the wire.
`default_nettype none

module siop_ext
    import siop_pkg::*;
(
    // Block side
    input  wire logic [NPIN-1:0] pin_out,
    input  wire logic [NPIN-1:0] pin_oe_n,
    // Instrument drive
    input  wire logic [NPIN-1:0] ext_en,
    input  wire logic [NPIN-1:0] ext_lvl,
    // Resolved wire
    output logic [NPIN-1:0]      pin_in
);
    timeunit 1ns;
    timeprecision 1ps;

    always_comb begin
        for (int i = 0; i < NPIN; i++) begin
            if (!pin_oe_n[i]) begin
                pin_in[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pin_in[i] = ext_lvl[i];
            end else begin
                pin_in[i] = 1'b1; // Open pin pulled high
            end
        end
    end
endmodule : siop_ext

`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking bench for the two status/general I/O pins.
// Assumes the instrument model resolves the pin wires.
`default_nettype none

module tb_top
    import siop_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic            hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0]     haddr, hwdata, hrdata;
    logic [1:0]      htrans;
    logic [2:0]      hsize;
    logic            protection_active, output_on;
    logic [NPIN-1:0] pin_in, pin_out, pin_oe_n, ext_en, ext_lvl;
    int              err_total, cmp_count;

    siop_pins uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .protection_active(protection_active), .output_on(output_on),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n));

    siop_ext ext (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_en(ext_en),
        .ext_lvl(ext_lvl), .pin_in(pin_in));

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    task automatic chk_reg(input string nm, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask : chk_reg

    task automatic chk_pin(input string nm, input logic [1:0] e, g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s exp %b got %b", nm, e, g);
        end
    endtask : chk_pin

    // Single word transfer; waits on hready, no fixed latency
    task automatic ahb(input logic w, input logic [31:0] a, d,
                       output logic [31:0] q);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : ahb

    task automatic wr(input logic [31:0] a, d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
    endtask : wr

    task automatic rd_chk(input string nm, input logic [31:0] a, e);
        logic [31:0] q;
        ahb(1'b0, a, 32'h0000_0000, q);
        chk_reg(nm, e, q);
        chk_reg("hresp", 32'h0000_0000, 32'(hresp));
    endtask : rd_chk

    function automatic logic [31:0] cfg(input int f, i, s);
        return {26'h0, 2'(s), 1'b0, 1'(i), 2'(f)};
    endfunction : cfg

    function automatic logic [31:0] adr(input logic [7:0] base, input int p);
        return {24'h00_0000, base + 8'(p)};
    endfunction : adr

    task automatic t_reset;
        chk_pin("reset pins", 2'b11, pin_out);
        chk_pin("reset oe", 2'b00, pin_oe_n);
        rd_chk("cfg0", adr(CFG_BASE, 0), 32'h0000_0000);
        rd_chk("cfg1", adr(CFG_BASE, 4), 32'h0000_0000);
        rd_chk("freq0", adr(FREQ_BASE, 0), 32'h0000_0064);
        rd_chk("duty1", adr(DUTY_BASE, 8), 32'h0000_000A);
        rd_chk("unmapped", 32'h0000_001C, 32'h0000_0000);
        rd_chk("status", 32'(STATUS_ADDR), 32'h0000_000C);
        wr(adr(CFG_BASE, 0), 32'h0000_0037);
        rd_chk("cfg code3", adr(CFG_BASE, 0), 32'h0000_0004);
    endtask : t_reset

    task automatic t_status;
        logic [1:0] e;
        for (int i = 0; i < 2; i++) begin
            wr(adr(CFG_BASE, 0), cfg(FN_STATUS, i, SEL_TRUE));
            wr(adr(CFG_BASE, 4), cfg(FN_STATUS, i, SEL_TRUE));
            for (int k = 0; k < 4; k++) begin
                protection_active <= k[0];
                output_on         <= k[1];
                repeat (3) @(posedge hclk);
                e = {~(k[1] ^ i[0]), ~(k[0] ^ i[0])};
                chk_pin("status pins", e, pin_out);
                rd_chk("status", 32'(STATUS_ADDR),
                       {26'h0, k[1:0], e, 2'b00});
            end
        end
    endtask : t_status

    task automatic t_output;
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 2; i++) begin
                for (int s = 0; s < 2; s++) begin
                    wr(adr(CFG_BASE, 4 * p), cfg(FN_OUTPUT, i, s));
                    repeat (3) @(posedge hclk);
                    chk_pin("out level", {1'b0, ~(s[0] ^ i[0])},
                            2'(pin_out[p]));
                    chk_pin("out oe", 2'b00, 2'(pin_oe_n[p]));
                end
            end
        end
    endtask : t_output

    task automatic t_input;
        logic [31:0] q;
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 2; i++) begin
                ext_en[p] <= 1'b0;
                wr(adr(CFG_BASE, 4 * p), cfg(FN_INPUT, i, SEL_FALSE));
                repeat (3) @(posedge hclk);
                chk_pin("in oe", 2'b01, 2'(pin_oe_n[p]));
                ahb(1'b0, 32'(STATUS_ADDR), 32'h0000_0000, q);
                chk_pin("open in", {1'b0, ~i[0]}, 2'(q[p]));
                ext_en[p]  <= 1'b1;
                ext_lvl[p] <= 1'b0;
                repeat (3) @(posedge hclk);
                ahb(1'b0, 32'(STATUS_ADDR), 32'h0000_0000, q);
                chk_pin("driven in", 2'(i[0]), 2'(q[p]));
            end
        end
    endtask : t_input

    // Pin p inverted when p is 1; period must divide 200 cycles
    task automatic pwm_chk(input int p, f, d);
        int n;
        int k;
        logic was;
        n = 0;
        k = 0;
        wr(adr(FREQ_BASE, 8 * p), 32'(f));
        wr(adr(DUTY_BASE, 8 * p), 32'(d));
        wr(adr(CFG_BASE, 4 * p), cfg(FN_OUTPUT, p, SEL_PWM));
        repeat (5) @(posedge hclk);
        // Low phase is logic 1, a pin level equal to the invert bit
        was = (pin_out[p] === 1'(p));
        repeat (200) begin
            @(posedge hclk);
            if (pin_out[p] === 1'(p)) begin
                n++;
                if (!was) k++;
            end
            was = (pin_out[p] === 1'(p));
        end
        chk_reg("pwm low", 32'(2 * d), 32'(n));
        // 200 cycles hold 200*f/1e8 periods
        chk_reg("pwm starts", 32'(d % 100 ? f / 500_000 : 0), 32'(k));
    endtask : pwm_chk

    task automatic t_pwm;
        wr(adr(DUTY_BASE, 0), 32'h0000_0078);
        rd_chk("duty sat", adr(DUTY_BASE, 0), 32'h0000_0064);
        wr(adr(FREQ_BASE, 0), 32'h0393_8700);
        rd_chk("freq sat", adr(FREQ_BASE, 0), 32'h02FA_F080);
        pwm_chk(0, 32'h000F_4240, 10);
        pwm_chk(0, 32'h000F_4240, 100);
        pwm_chk(0, 32'h000F_4240, 0);
        pwm_chk(1, 32'h001E_8480, 30);
    endtask : t_pwm

    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'b010;
        {protection_active, output_on, ext_en, ext_lvl} = '0;
        err_total = 0;
        cmp_count = 0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        t_reset();
        t_status();
        t_output();
        t_input();
        t_pwm();
        finish_test();
    end

    // Whole run is about 1100 cycles; this is well past it
    initial begin
        repeat (20000) @(posedge hclk);
        err_total++;
        finish_test();
    end
endmodule : tb_top

`default_nettype wire
